// *** src/dfrc_top.sv ***
// Purpose: drive settings, fault reactions, error history and emergency message
// Assumes: settings arrive as write strobes from the drive parameter store
// Notes: history kept in an internal array indexed by sub-index
// Functional notes
// - speed reference source: keypad, analog, serial, network card, pulse train
// - run command source: keypad, analog, serial, network card; default 1
// - pole count accepted 2 to 48, default 4, used for rpm
// - link fault reaction 0..5 selects ramp, coast, fast, alarm, fallback, alarm-ramp
// - external fault detected always (0) or only while running (1)
// - external fault reaction ramp, coast, fast stop or alarm only
// - network torque reference and limit disabled (0) or enabled (1)
// - multi-step references allowed on network or serial reference only if set
// - initialisation also resets communication settings only when scope is 1
// - display units: 0.01 Hz, 0.01 percent, rpm, user units
// - display units also set units of reference, output and speed objects
// - each fault stored in next history sub-index; sub-index 0 counts to FF
// - one emergency message per fault or alarm occurrence
// - message: error code, error register value 1, then zero bytes
module dfrc_top
   import dfrc_pkg::*;
#(
   parameter int HIST_DEPTH = 255
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // settings write port
   input wire logic i_set_we,
   input wire logic [3:0] i_set_sel,
   input wire logic [7:0] i_set_data,
   input wire logic i_param_init_cmd,
   // drive status and fault sources
   input wire logic i_running,
   input wire logic i_link_fault,
   input wire logic i_option_external_fault,
   input wire logic i_fault_valid,
   input wire logic [15:0] i_fault_code,
   // object access port
   input wire logic i_obj_rd,
   input wire logic i_obj_wr,
   input wire logic [15:0] i_obj_index,
   input wire logic [7:0] i_obj_sub,
   input wire logic [31:0] i_obj_wdata,
   output logic [31:0] o_obj_rdata,
   output logic o_obj_ack,
   output logic o_obj_err,
   // emergency message
   output logic o_emcy_valid,
   output logic [63:0] o_emcy_msg,
   // effective configuration towards drive core
   output logic [2:0] o_speed_ref_source_select,
   output logic [2:0] o_run_cmd_source_select,
   output logic o_net_ref_active,
   output logic o_net_run_active,
   output logic [5:0] o_motor_pole_count,
   output logic [1:0] o_freq_display_units,
   output logic o_rpm_units_active,
   output logic o_net_torque_enable,
   output logic o_multistep_enable,
   output logic [2:0] o_stop_action,
   output logic o_ext_fault_active
);
   logic [2:0] speed_src_r;
   logic [2:0] run_src_r;
   logic [5:0] poles_r;
   logic [2:0] link_react_r;
   logic [1:0] ext_react_r;
   logic ext_det_r, torque_r, multi_r, scope_r;
   logic [1:0] units_r;
   logic [7:0] err_count_r;
   logic [15:0] hist_r [1:HIST_DEPTH];
   logic link_meta_r, link_s2_r, link_s3_r;
   logic ext_meta_r, ext_s2_r, ext_s3_r;
   logic link_flt_r, ext_flt_r;
   logic [15:0] last_code_r;
   logic fault_prev_r, new_fault, ext_hit;

   function automatic dfrc_action_e react_of(input logic [2:0] sel);
      case (sel)
         3'h0: react_of = DFRC_ACT_RAMP;
         3'h1: react_of = DFRC_ACT_COAST;
         3'h2: react_of = DFRC_ACT_FAST;
         3'h3: react_of = DFRC_ACT_ALARM;
         3'h4: react_of = DFRC_ACT_FALLBACK;
         3'h5: react_of = DFRC_ACT_RAMP; // alarm then ramp
         default: react_of = DFRC_ACT_COAST;
      endcase
   endfunction : react_of

   // settings; out-of-range writes are ignored so the last legal value stays
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         speed_src_r <= SRC_OPTION_CARD;
         run_src_r <= RUN_SRC_RST;
         poles_r <= POLE_RST;
         link_react_r <= LINK_REACT_RST;
         ext_det_r <= 1'b0;
         ext_react_r <= EXT_REACT_RST;
         torque_r <= 1'b0;
         multi_r <= 1'b0;
         scope_r <= 1'b0;
         units_r <= 2'h0;
      end
      else if (i_param_init_cmd && scope_r)
      begin
         // communication group restored only when scope allows it
         link_react_r <= LINK_REACT_RST;
         ext_det_r <= 1'b0;
         ext_react_r <= EXT_REACT_RST;
         torque_r <= 1'b0;
         multi_r <= 1'b0;
         scope_r <= 1'b0;
      end
      else if (i_set_we)
      begin
         case (i_set_sel)
            SEL_SPEED: if (i_set_data[7:3] == 5'h00 && i_set_data[2:0] <= SRC_MAX_SPEED)
               speed_src_r <= i_set_data[2:0];
            SEL_RUN: if (i_set_data[7:3] == 5'h00 && i_set_data[2:0] <= SRC_MAX_RUN)
               run_src_r <= i_set_data[2:0];
            SEL_POLE: if (i_set_data[7:6] == 2'h0 && i_set_data[5:0] >= POLE_MIN
                          && i_set_data[5:0] <= POLE_MAX)
               poles_r <= i_set_data[5:0];
            SEL_LINK: if (i_set_data[7:3] == 5'h00 && i_set_data[2:0] <= LINK_REACT_MAX)
               link_react_r <= i_set_data[2:0];
            SEL_EXTDET: if (i_set_data[7:1] == 7'h00)
               ext_det_r <= i_set_data[0];
            SEL_EXTREACT: if (i_set_data[7:2] == 6'h00)
               ext_react_r <= i_set_data[1:0];
            SEL_TORQUE: if (i_set_data[7:1] == 7'h00)
               torque_r <= i_set_data[0];
            SEL_MULTI: if (i_set_data[7:1] == 7'h00)
               multi_r <= i_set_data[0];
            SEL_SCOPE: if (i_set_data[7:1] == 7'h00)
               scope_r <= i_set_data[0];
            SEL_UNITS: if (i_set_data[7:2] == 6'h00)
               units_r <= i_set_data[1:0];
            default: ;
         endcase
      end
   end

   // fault pins cross in through three stages; second and third must agree
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {link_meta_r, link_s2_r, link_s3_r} <= 3'b000;
         {ext_meta_r, ext_s2_r, ext_s3_r} <= 3'b000;
         link_flt_r <= 1'b0;
         ext_flt_r <= 1'b0;
      end
      else
      begin
         {link_meta_r, link_s2_r, link_s3_r} <= {i_link_fault, link_meta_r, link_s2_r};
         {ext_meta_r, ext_s2_r, ext_s3_r} <= {i_option_external_fault, ext_meta_r, ext_s2_r};
         if (link_s2_r == link_s3_r)
            link_flt_r <= link_s3_r;
         if (ext_s2_r == ext_s3_r)
            ext_flt_r <= ext_s3_r;
      end
   end

   assign ext_hit = ext_flt_r && (!ext_det_r || i_running);
   // stop action: link fault has priority over external fault
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_stop_action <= DFRC_ACT_NONE;
         o_ext_fault_active <= 1'b0;
      end
      else
      begin
         o_ext_fault_active <= ext_hit;
         if (link_flt_r)
            o_stop_action <= react_of(link_react_r);
         else if (ext_hit)
            o_stop_action <= react_of({1'b0, ext_react_r});
         else
            o_stop_action <= DFRC_ACT_NONE;
      end
   end

   // configuration outputs towards drive core
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_speed_ref_source_select <= SRC_OPTION_CARD;
         o_run_cmd_source_select <= RUN_SRC_RST;
         o_net_ref_active <= 1'b1; // source resets to the network card
         o_net_run_active <= 1'b0;
         o_motor_pole_count <= POLE_RST;
         o_freq_display_units <= 2'h0;
         o_rpm_units_active <= 1'b0;
         o_net_torque_enable <= 1'b0;
         o_multistep_enable <= 1'b0;
      end
      else
      begin
         o_speed_ref_source_select <= speed_src_r;
         o_run_cmd_source_select <= run_src_r;
         o_net_ref_active <= (speed_src_r == SRC_OPTION_CARD);
         o_net_run_active <= (run_src_r == SRC_OPTION_CARD);
         o_motor_pole_count <= poles_r;
         // one unit code serves reference, output and speed objects alike
         o_freq_display_units <= units_r;
         o_rpm_units_active <= (units_r == UNITS_RPM);
         o_net_torque_enable <= torque_r;
         // multi-step only blocked when the reference is from a link
         o_multistep_enable <= multi_r || !(speed_src_r == SRC_OPTION_CARD
                               || speed_src_r == SRC_SERIAL_LINK);
      end
   end
   // a fault is new on its rising strobe or when its code changes
   assign new_fault = i_fault_valid && (!fault_prev_r || i_fault_code != last_code_r);

   // history and emergency message
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         fault_prev_r <= 1'b0;
         last_code_r <= 16'h0000;
         err_count_r <= ERROR_COUNT_RST;
         o_emcy_valid <= 1'b0;
         o_emcy_msg <= 64'h0000000000000000;
      end
      else
      begin
         fault_prev_r <= i_fault_valid;
         o_emcy_valid <= new_fault;
         if (i_fault_valid)
            last_code_r <= i_fault_code;
         if (new_fault)
         begin
            // byte 0..1 code little-endian, byte 2 error register, rest zero
            o_emcy_msg <= {40'h0000000000, ERROR_REG_VALUE, i_fault_code};
            // saturates at FF; logging wins over a same-cycle count write
            if (err_count_r != ERROR_COUNT_MAX)
               err_count_r <= err_count_r + 8'h01;
         end
         else if (i_obj_wr && i_obj_index == OBJ_ERROR_HISTORY && i_obj_sub == SUB_ERROR_COUNT)
            err_count_r <= i_obj_wdata[7:0];
      end
   end

   // history array has no reset; entries beyond count are stale by design
   always_ff @(posedge i_clk_sys)
   begin
      if (new_fault && err_count_r != ERROR_COUNT_MAX && int'(err_count_r) < HIST_DEPTH)
         hist_r[int'(err_count_r) + 1] <= i_fault_code;
   end

   // object read and write answers, one cycle after the request
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_obj_rdata <= 32'h00000000;
         o_obj_ack <= 1'b0;
         o_obj_err <= 1'b0;
      end
      else
      begin
         o_obj_ack <= i_obj_rd || i_obj_wr;
         o_obj_err <= 1'b0;
         o_obj_rdata <= 32'h00000000;
         if (i_obj_rd && i_obj_index == OBJ_ERROR_HISTORY)
         begin
            if (i_obj_sub == SUB_ERROR_COUNT)
               o_obj_rdata <= {24'h000000, err_count_r};
            else if (i_obj_sub <= err_count_r && int'(i_obj_sub) <= HIST_DEPTH)
               o_obj_rdata <= {16'h0000, hist_r[int'(i_obj_sub)]};
            else
               o_obj_err <= 1'b1;
         end
         else if (i_obj_rd && i_obj_index == OBJ_ERROR_REGISTER)
            o_obj_rdata <= {24'h000000, ERROR_REG_VALUE};
         else if (i_obj_rd)
            o_obj_err <= 1'b1;
         else if (i_obj_wr && !(i_obj_index == OBJ_ERROR_HISTORY && i_obj_sub == SUB_ERROR_COUNT))
            o_obj_err <= 1'b1; // entries are read-only
      end
   end
endmodule : dfrc_top

// *** src/dfrc_pkg.sv ***
// Purpose: constants for the drive fault reporting and configuration block
// Assumes: one clock, asynchronous active-low reset
// Notes: object indices kept as printed; access is by index and sub-index
package dfrc_pkg;
   // object indices and sub-indices
   localparam logic [15:0] OBJ_ERROR_HISTORY = 16'h1003;
   localparam logic [15:0] OBJ_ERROR_REGISTER = 16'h1001;
   localparam logic [7:0] SUB_ERROR_COUNT = 8'h00;
   localparam logic [7:0] ERROR_COUNT_MAX = 8'hFF;
   localparam logic [7:0] ERROR_REG_VALUE = 8'h01;
   localparam logic [7:0] ERROR_COUNT_RST = 8'h00;
   // setting encodings
   localparam logic [2:0] SRC_OPTION_CARD = 3'h3;
   localparam logic [2:0] SRC_SERIAL_LINK = 3'h2;
   localparam logic [2:0] SRC_MAX_SPEED = 3'h4;
   localparam logic [2:0] SRC_MAX_RUN = 3'h3;
   localparam logic [2:0] RUN_SRC_RST = 3'h1;
   localparam logic [5:0] POLE_MIN = 6'h02;
   localparam logic [5:0] POLE_MAX = 6'h30;
   localparam logic [5:0] POLE_RST = 6'h04;
   localparam logic [2:0] LINK_REACT_RST = 3'h1;
   localparam logic [2:0] LINK_REACT_MAX = 3'h5;
   localparam logic [1:0] EXT_REACT_RST = 2'h1;
   localparam logic [1:0] UNITS_RPM = 2'h2;
   // setting selectors on the settings write port
   localparam logic [3:0] SEL_SPEED = 4'h0;
   localparam logic [3:0] SEL_RUN = 4'h1;
   localparam logic [3:0] SEL_POLE = 4'h2;
   localparam logic [3:0] SEL_LINK = 4'h3;
   localparam logic [3:0] SEL_EXTDET = 4'h4;
   localparam logic [3:0] SEL_EXTREACT = 4'h5;
   localparam logic [3:0] SEL_TORQUE = 4'h6;
   localparam logic [3:0] SEL_MULTI = 4'h7;
   localparam logic [3:0] SEL_SCOPE = 4'h8;
   localparam logic [3:0] SEL_UNITS = 4'h9;
   // stop reactions presented to the drive core
   typedef enum logic [2:0]
   {
      DFRC_ACT_NONE = 3'b000,
      DFRC_ACT_RAMP = 3'b001,
      DFRC_ACT_COAST = 3'b010,
      DFRC_ACT_FAST = 3'b011,
      DFRC_ACT_ALARM = 3'b100,
      DFRC_ACT_FALLBACK = 3'b101
   } dfrc_action_e;
endpackage : dfrc_pkg

// *** tb/dfrc_chk.sv ***
// Purpose: port checker for the fault reporting and settings block
// Assumes: one clock domain, reset active low
// Notes: bound to every dfrc_top instance
module dfrc_chk
   import dfrc_pkg::*;
#(
   parameter int HIST_DEPTH = 255
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // inputs watched
   input wire logic i_set_we,
   input wire logic [3:0] i_set_sel,
   input wire logic [7:0] i_set_data,
   input wire logic i_link_fault,
   input wire logic i_option_external_fault,
   input wire logic i_fault_valid,
   input wire logic [15:0] i_fault_code,
   input wire logic i_obj_rd,
   input wire logic i_obj_wr,
   input wire logic [15:0] i_obj_index,
   // outputs watched
   input wire logic [31:0] o_obj_rdata,
   input wire logic o_obj_ack,
   input wire logic o_obj_err,
   input wire logic o_emcy_valid,
   input wire logic [63:0] o_emcy_msg,
   input wire logic [2:0] o_speed_ref_source_select,
   input wire logic o_net_ref_active,
   input wire logic [5:0] o_motor_pole_count,
   input wire logic [2:0] o_stop_action,
   input wire logic o_ext_fault_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // new fault: rising valid or a changed code
   sequence s_new;
      i_fault_valid && (!$past(i_fault_valid) || i_fault_code != $past(i_fault_code));
   endsequence
   a_emcy_new_fault: assert property (s_new
      |=> o_emcy_valid && o_emcy_msg == {40'h0, ERROR_REG_VALUE, $past(i_fault_code)})
      else $error("emergency message missing or wrong");
   a_emcy_no_repeat: assert property (i_fault_valid && $past(i_fault_valid) && $stable(i_fault_code)
      |=> !o_emcy_valid)
      else $error("emergency message repeated");
   a_ack_one_cycle: assert property (o_obj_ack == $past(i_obj_rd || i_obj_wr))
      else $error("object answer not one cycle after request");
   a_err_reg_read: assert property (i_obj_rd && i_obj_index == OBJ_ERROR_REGISTER
      |=> o_obj_rdata == 32'(ERROR_REG_VALUE) && !o_obj_err)
      else $error("error register object not one");
   a_pole_in_range: assert property (o_motor_pole_count >= POLE_MIN && o_motor_pole_count <= POLE_MAX)
      else $error("pole count out of range");
   a_pole_update: assert property (i_set_we && i_set_sel == 4'h2 && i_set_data >= 8'h02 && i_set_data <= 8'h30
      |=> ##1 o_motor_pole_count == $past(i_set_data, 2))
      else $error("legal pole count not taken");
   a_net_ref_flag: assert property (1'b1 |=> o_net_ref_active == (o_speed_ref_source_select == SRC_OPTION_CARD))
      else $error("network reference flag wrong");
   a_idle_no_action: assert property ((!i_link_fault && !i_option_external_fault)[*8]
      |-> o_stop_action == DFRC_ACT_NONE && !o_ext_fault_active)
      else $error("stop action without fault");
   c_emcy: cover property (o_emcy_valid);
   c_obj_err: cover property (o_obj_ack && o_obj_err);
   c_fallback: cover property (o_stop_action == DFRC_ACT_FALLBACK);
endmodule : dfrc_chk

bind dfrc_top dfrc_chk #(.HIST_DEPTH(HIST_DEPTH)) u_chk (.i_clk_sys, .i_rst_n, .i_set_we, .i_set_sel, .i_set_data,
   .i_link_fault, .i_option_external_fault, .i_fault_valid, .i_fault_code, .i_obj_rd, .i_obj_wr, .i_obj_index,
   .o_obj_rdata, .o_obj_ack, .o_obj_err, .o_emcy_valid, .o_emcy_msg, .o_speed_ref_source_select,
   .o_net_ref_active, .o_motor_pole_count, .o_stop_action, .o_ext_fault_active);

// *** tb/dfrc_master.sv ***
// Purpose: network master model issuing object reads and writes
// Assumes: one request pulse, answer one cycle later
// Notes: address lines scrambled once the answer is taken
module dfrc_master
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // request from bench
   input wire logic i_go,
   input wire logic i_wr,
   input wire logic [15:0] i_index,
   input wire logic [7:0] i_sub,
   input wire logic [31:0] i_wdata,
   // object port of the drive
   output logic o_obj_rd,
   output logic o_obj_wr,
   output logic [15:0] o_obj_index,
   output logic [7:0] o_obj_sub,
   output logic [31:0] o_obj_wdata,
   input wire logic [31:0] i_obj_rdata,
   input wire logic i_obj_ack,
   input wire logic i_obj_err,
   // result to bench
   output logic o_done,
   output logic [31:0] o_rdata,
   output logic o_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_r;
   // one pulse per request; stale address never left on the port
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {o_obj_rd, o_obj_wr, o_done, busy_r, o_obj_index, o_obj_sub, o_obj_wdata, o_rdata, o_err} <= '0;
      end
      else
      begin
         o_obj_rd <= i_go && !busy_r && !i_wr;
         o_obj_wr <= i_go && !busy_r && i_wr;
         o_done <= i_obj_ack;
         if (i_go && !busy_r)
         begin
            busy_r <= 1'b1;
            {o_obj_index, o_obj_sub, o_obj_wdata} <= {i_index, i_sub, i_wdata};
         end
         if (i_obj_ack)
         begin
            busy_r <= 1'b0;
            {o_rdata, o_err} <= {i_obj_rdata, i_obj_err};
            {o_obj_index, o_obj_sub, o_obj_wdata} <= ~{o_obj_index, o_obj_sub, o_obj_wdata};
         end
      end
   end
endmodule : dfrc_master

// *** tb/tb.sv ***
// Purpose: self-checking bench for the fault reporting and settings block
// Assumes: inputs driven at the falling edge
// Notes: short history depth keeps the run brief
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // stimulus, partner and observed signals
   logic i_clk_sys = 1'b0;
   logic i_rst_n;
   logic i_set_we = 1'b0, i_param_init_cmd = 1'b0, i_running = 1'b0, i_link_fault = 1'b0;
   logic i_option_external_fault = 1'b0, i_fault_valid = 1'b0, go = 1'b0, gwr = 1'b0, done, merr;
   logic [3:0] i_set_sel = 4'h0;
   logic [7:0] i_set_data = 8'h00, i_obj_sub, gsub = 8'h00, p;
   logic [15:0] i_fault_code = 16'h0000, i_obj_index, gidx = 16'h0000;
   logic [31:0] i_obj_wdata, o_obj_rdata, gwd = 32'h0, mrd;
   logic i_obj_rd, i_obj_wr, o_obj_ack, o_obj_err, o_emcy_valid, o_net_ref_active, o_net_run_active;
   logic o_rpm_units_active, o_net_torque_enable, o_multistep_enable, o_ext_fault_active;
   logic [63:0] o_emcy_msg;
   logic [2:0] o_speed_ref_source_select, o_run_cmd_source_select, o_stop_action;
   logic [5:0] o_motor_pole_count;
   logic [1:0] o_freq_display_units;
   logic [15:0] codes[$];
   int errors = 0, samples_checked = 0, cycles = 0, seed = 32'hDD4B02AB;
   dfrc_top #(.HIST_DEPTH(8)) dut (.i_clk_sys, .i_rst_n, .i_set_we, .i_set_sel, .i_set_data, .i_param_init_cmd,
      .i_running, .i_link_fault, .i_option_external_fault, .i_fault_valid, .i_fault_code, .i_obj_rd, .i_obj_wr,
      .i_obj_index, .i_obj_sub, .i_obj_wdata, .o_obj_rdata, .o_obj_ack, .o_obj_err, .o_emcy_valid, .o_emcy_msg,
      .o_speed_ref_source_select, .o_run_cmd_source_select, .o_net_ref_active, .o_net_run_active,
      .o_motor_pole_count, .o_freq_display_units, .o_rpm_units_active, .o_net_torque_enable,
      .o_multistep_enable, .o_stop_action, .o_ext_fault_active);
   dfrc_master m (.i_clk_sys, .i_rst_n, .i_go(go), .i_wr(gwr), .i_index(gidx), .i_sub(gsub), .i_wdata(gwd),
      .o_obj_rd(i_obj_rd), .o_obj_wr(i_obj_wr), .o_obj_index(i_obj_index), .o_obj_sub(i_obj_sub),
      .o_obj_wdata(i_obj_wdata), .i_obj_rdata(o_obj_rdata), .i_obj_ack(o_obj_ack), .i_obj_err(o_obj_err),
      .o_done(done), .o_rdata(mrd), .o_err(merr));
   // 50 MHz clock
   always #10 i_clk_sys = ~i_clk_sys;
   // stop action for reaction codes; code 5 ramps
   function automatic logic [2:0] react(input int r);
      return (r == 5) ? 3'h1 : 3'(r + 1);
   endfunction : react
   task check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : tick
   // copies land two edges after the write
   task set(input logic [3:0] s, input logic [7:0] d);
      i_set_we = 1'b1;
      i_set_sel = s;
      i_set_data = d;
      tick(1);
      i_set_we = 1'b0;
      tick(2);
   endtask : set
   task obj(input logic w, input logic [15:0] i, input logic [7:0] s);
      {go, gwr, gidx, gsub, gwd} = {1'b1, w, i, s, 32'h0};
      tick(1);
      go = 1'b0;
      for (int k = 0; k < 6 && done !== 1'b1; k++)
         tick(1);
   endtask : obj
   // held fault must not announce itself twice
   task fault(input logic [15:0] c);
      if (c == i_fault_code)
         c = ~c;
      codes.push_back(c);
      {i_fault_valid, i_fault_code} = {1'b1, c};
      // the message pulse stands for the single cycle after the new fault
      tick(1);
      check(o_emcy_valid, 1);
      check(o_emcy_msg, {40'h0, 8'h01, c});
      tick(2);
      check(o_emcy_valid, 0);
   endtask : fault
   // main sequence
   initial
   begin
      i_rst_n = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      tick(1);
      i_rst_n = 1'b1;
      check({o_speed_ref_source_select, o_run_cmd_source_select, o_motor_pole_count}, {3'h3, 3'h1, 6'h04});
      obj(0, 16'h1003, 8'h00);
      check({merr, mrd}, 0);
      for (int v = 0; v < 6; v++)
      begin
         set(0, 8'(v));
         check(o_speed_ref_source_select, (v == 5) ? 4 : v);
         check({o_net_ref_active, o_multistep_enable}, {v == 3, v < 2 || v > 3});
      end
      set(7, 1);
      set(0, 2);
      check(o_multistep_enable, 1);
      for (int v = 0; v < 5; v++)
      begin
         set(1, 8'(v));
         check({o_run_cmd_source_select, o_net_run_active}, {(v == 4) ? 3'h3 : 3'(v), v > 2});
      end
      set(2, 8'h01);
      set(2, 8'h31);
      check(o_motor_pole_count, 4);
      repeat (4)
      begin
         p = 8'(2 + {$random(seed)} % 47);
         set(2, p);
         check(o_motor_pole_count, p);
      end
      // rpm units chosen last, pole count already set
      for (int v = 0; v < 4; v++)
      begin
         set(9, 8'(v ^ 1));
         check({o_freq_display_units, o_rpm_units_active}, {2'(v ^ 1), (v ^ 1) == 2});
      end
      // torque values themselves stay the master's job
      set(6, 1);
      for (int s = 0; s < 2; s++)
      begin
         set(8, 8'(s));
         i_param_init_cmd = 1'b1;
         tick(1);
         i_param_init_cmd = 1'b0;
         tick(2);
         check(o_net_torque_enable, s == 0);
      end
      for (int r = 0; r < 6; r++)
      begin
         set(3, 8'(r));
         i_link_fault = 1'b1;
         tick(8);
         check(o_stop_action, react(r));
         i_link_fault = 1'b0;
         tick(8);
      end
      set(4, 1);
      i_option_external_fault = 1'b1;
      tick(8);
      check(o_ext_fault_active, 0);
      i_running = 1'b1;
      tick(8);
      check(o_ext_fault_active, 1);
      for (int r = 0; r < 4; r++)
      begin
         set(5, 8'(r));
         tick(2);
         check(o_stop_action, react(r));
      end
      i_running = 1'b0;
      set(4, 0);
      tick(8);
      check(o_ext_fault_active, 1);
      i_option_external_fault = 1'b0;
      fault(16'h5481);
      repeat (5)
         fault(16'($random(seed)));
      i_fault_valid = 1'b0;
      tick(2);
      fault(16'h5481);
      i_fault_valid = 1'b0;
      tick(2);
      obj(0, 16'h1003, 8'h00);
      check(mrd, codes.size());
      foreach (codes[k])
      begin
         obj(0, 16'h1003, 8'(k + 1));
         check(mrd, codes[k]);
      end
      obj(0, 16'h1003, 8'(codes.size() + 1));
      check(merr, 1);
      obj(1, 16'h1003, 8'h00);
      obj(0, 16'h1003, 8'h00);
      check(mrd, 0);
      obj(0, 16'h1001, 8'h00);
      check(mrd, 1);
      obj(0, 16'h2000, 8'h00);
      check(merr, 1);
      results();
   end
   // hang guard
   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         results();
      end
   end
endmodule : tb
